// ### verilog/ofs_pkg.sv
package ofs_pkg;
  // ==========================================================
  // sizes and register map (word indices, byte address = 4 * index)
  localparam int NUM_OUT = 6;
  localparam int DIV_W = 7;
  localparam int ADDR_W = 12;
  localparam int WORD_W = ADDR_W - 2;
  localparam int FLD_W = 4;
  localparam logic [WORD_W-1:0] IDX_SEL12 = 10'h060;
  localparam logic [WORD_W-1:0] IDX_SEL34 = 10'h061;
  localparam logic [WORD_W-1:0] IDX_SEL56 = 10'h062;
  localparam logic [WORD_W-1:0] IDX_ALT = 10'h066;
  localparam logic [WORD_W-1:0] IDX_STAT = 10'h067;
  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] RST_SEL12 = 8'h85;
  localparam logic [7:0] RST_SEL34 = 8'h86;
  localparam logic [7:0] RST_SEL56 = 8'h84;
  localparam logic [NUM_OUT-1:0] RST_ALT = 6'h00;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 4;
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_BUSY_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // timing: quiet low time on every source switch
  localparam int CLK_NS = 5;
  localparam int HOLD_NS = 20;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // clock sources, code doubles as the index into the source vector
  localparam int SRC_N = 10;
  typedef enum logic [3:0] {
    SRC_OFF = 4'h0, SRC_2K = 4'h1, SRC_8K = 4'h2, SRC_SYN1 = 4'h3,
    SRC_SYN2 = 4'h4, SRC_MAIN = 4'h5, SRC_SEC = 4'h6, SRC_MAIN2 = 4'h7,
    SRC_SECREF = 4'h8, SRC_MAINREF = 4'h9
  } ofs_src_t;
endpackage : ofs_pkg

// ### verilog/ofs_chan_if.sv
`timescale 1ns/1ps
interface ofs_chan_if;
  import ofs_pkg::*;
  ofs_src_t req_src;
  logic [DIV_W-1:0] req_div;
  logic clk_out;
  logic busy;
  modport top (output req_src, output req_div, input clk_out, input busy);
  modport chan (input req_src, input req_div, output clk_out, output busy);
endinterface : ofs_chan_if

// ### verilog/ofs_divider.sv
`timescale 1ns/1ps
module ofs_divider import ofs_pkg::*; #(
  parameter int W = DIV_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // source level, divisor and restart
  input wire logic src_in,
  input wire logic [W-1:0] div,
  input wire logic clr,
  // divided level
  output logic div_out
);
  logic src_q, next_src_q, out_q, next_out;
  logic [W-1:0] cnt, next_cnt;
  logic edge_seen;

  // ==========================================================
  // edge counter; odd divisors give the extra cycle to the high phase
  always_comb begin
    edge_seen = src_in & ~src_q;
    next_src_q = src_in;
    next_cnt = cnt;
    if (clr) begin
      next_cnt = '0;
    end else if (edge_seen) begin
      next_cnt = (cnt == div - W'(1)) ? '0 : cnt + W'(1);
    end
    if (clr) begin
      next_out = 1'b0;
    end else if (div <= W'(1)) begin
      next_out = src_q; // undivided: pass the sampled source
    end else begin
      next_out = (next_cnt < ((div + W'(1)) >> 1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      src_q <= 1'b0;
      cnt <= '0;
      out_q <= 1'b0;
    end else begin
      src_q <= next_src_q;
      cnt <= next_cnt;
      out_q <= next_out;
    end
  end

  assign div_out = out_q;
endmodule : ofs_divider

// ### verilog/ofs_chan.sv
`timescale 1ns/1ps
module ofs_chan import ofs_pkg::*; #(
  parameter int HOLD = HOLD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // all clock sources as sampled levels
  input wire logic [SRC_N-1:0] src_vec,
  // request and output
  ofs_chan_if.chan port
);
  typedef enum logic [1:0] {ST_RUN = 2'b00, ST_DRAIN = 2'b01, ST_HOLD = 2'b10} ofs_st_t;
  ofs_st_t state, next_state;
  ofs_src_t act_src, next_act_src;
  logic [DIV_W-1:0] act_div, next_act_div;
  logic [3:0] hold_cnt, next_hold_cnt;
  logic out_q, next_out, div_out;

  // ==========================================================
  // switch sequencer: finish the current high phase, then hold low
  always_comb begin
    next_state = state;
    next_act_src = act_src;
    next_act_div = act_div;
    next_hold_cnt = hold_cnt;
    case (state)
      ST_RUN: begin
        if (port.req_src != act_src || port.req_div != act_div) begin
          next_state = ST_DRAIN; // [R16]
        end
      end
      ST_DRAIN: begin
        // never cut a high phase short, that would be a runt pulse
        if (!div_out) begin
          next_state = ST_HOLD; // [R16]
          next_act_src = port.req_src;
          next_act_div = port.req_div;
          next_hold_cnt = 4'(HOLD);
        end
      end
      ST_HOLD: begin
        next_act_src = port.req_src;
        next_act_div = port.req_div;
        if (port.req_src != act_src || port.req_div != act_div) begin
          next_hold_cnt = 4'(HOLD);
        end else if (hold_cnt <= 4'h1) begin
          next_state = ST_RUN;
        end else begin
          next_hold_cnt = hold_cnt - 4'h1;
        end
      end
      default: next_state = ST_HOLD;
    endcase
    next_out = (state != ST_HOLD) & div_out; // [R16]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_HOLD;
      act_src <= SRC_OFF;
      act_div <= DIV_W'(1);
      hold_cnt <= 4'(HOLD);
      out_q <= 1'b0;
    end else begin
      state <= next_state;
      act_src <= next_act_src;
      act_div <= next_act_div;
      hold_cnt <= next_hold_cnt;
      out_q <= next_out;
    end
  end

  // ==========================================================
  // divider, restarted while held low so the new source starts clean
  ofs_divider #(.W(DIV_W)) u_div (
    .clk(clk),
    .rst(rst),
    .src_in(src_vec[act_src]),
    .div(act_div),
    .clr(state == ST_HOLD),
    .div_out(div_out)
  );

  assign port.clk_out = out_q;
  assign port.busy = (state != ST_RUN);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_drain_done;
    (state == ST_DRAIN) ##1 (state == ST_HOLD);
  endsequence

  chk_hold_low: assert property ((state == ST_HOLD) |=> !out_q) // [R16]
    else $error("output not low while switching");
  chk_switch_clean: assert property (s_drain_done |-> !out_q && $past(!div_out)) // [R16]
    else $error("switch left output on a high phase");
  chk_off_low: assert property ((state == ST_RUN && act_src == SRC_OFF) |=> !out_q) // [R3]
    else $error("disabled output not low");
endmodule : ofs_chan

// ### verilog/ofs_top.sv
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// R1: six 4-bit select fields, two per register, low nibble odd output.
// R2: each output has its own alternate-decode bit choosing the code table.
// R3: code 0000 holds the output low in both tables.
// R4: standard 0001 gives 2 kHz, 0010 gives 8 kHz.
// R5: standard 0011 gives synth two, 0100 gives synth one; output six here takes main PLL /2 on 0011.
// R6: outputs two and four: 0101..1010 main PLL /48,/16,/12,/8,/6,/4.
// R7: outputs one and three: code 1001 gives main PLL /8.
// R8: outputs one to three: 1011..1111 secondary PLL /64,/48,/16,/8,/4.
// R9: output four: code 1011 gives secondary PLL /2.
// R10: alternate outputs two, three: main /64, secondary /20,/12,/10,/5,/2.
// R11: alternate output one: 0101 second main PLL /10, 0110 /5.
// R12: alternate output four: main /2, main, sec /10, main2 /2 twice, main2.
// R13: alternate 0111 secondary reference, 1000 main reference, both divided.
// R14: host never writes alternate codes 1001..1111; those drive low here.
// R15: output six field uses output six's own alternate-decode bit.
// R16: source changes pass through a held-low state, never runt pulses.
module ofs_top import ofs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock sources, sampled as levels
  input wire logic frame_2k_clk,
  input wire logic frame_8k_clk,
  input wire logic digital_synth_one,
  input wire logic digital_synth_two,
  input wire logic main_path_analog_pll,
  input wire logic secondary_path_analog_pll,
  input wire logic main_path_second_pll,
  input wire logic secondary_ref_div,
  input wire logic main_ref_div,
  // output clocks
  output logic clock_output_one,
  output logic clock_output_two,
  output logic clock_output_three,
  output logic clock_output_four,
  output logic clock_output_five,
  output logic clock_output_six
);
  logic [7:0] sel_reg [3];
  logic [7:0] next_sel [3];
  logic [NUM_OUT-1:0] alt_reg, next_alt;
  logic aw_got, next_aw_got, w_got, next_w_got, wr_fire;
  logic [WORD_W-1:0] aw_word, next_aw_word;
  logic [7:0] wdata_q, next_wdata;
  logic wstrb_q, next_wstrb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp_q, next_bresp, rresp_q, next_rresp;
  logic [31:0] rdata_q, next_rdata;
  logic [WORD_W-1:0] ar_word;
  logic [FLD_W-1:0] fld [NUM_OUT];
  ofs_src_t req_src [NUM_OUT];
  ofs_src_t next_req_src [NUM_OUT];
  logic [DIV_W-1:0] req_div [NUM_OUT];
  logic [DIV_W-1:0] next_req_div [NUM_OUT];
  logic [NUM_OUT-1:0] clk_v, busy_v;
  logic [SRC_N-1:0] src_vec;
  logic [DIV_W+3:0] dec;

  // ==========================================================
  // code tables
  function automatic logic [DIV_W+3:0] pk(ofs_src_t s, int d);
    return {s, DIV_W'(d)};
  endfunction : pk

  // idx is the output number minus one
  function automatic logic [DIV_W+3:0] decode(int idx, logic alt, logic [3:0] c);
    logic g13;
    logic g45;
    logic g6;
    logic [DIV_W+3:0] r;
    g13 = (idx == 0) || (idx == 2);
    g45 = (idx == 3) || (idx == 4);
    g6 = (idx == 5);
    r = pk(SRC_OFF, 1); // [R3]
    if (!alt) begin
      case (c)
        4'h1: r = pk(SRC_2K, 1); // [R4]
        4'h2: r = pk(SRC_8K, 1); // [R4]
        4'h3: r = g6 ? pk(SRC_MAIN, 2) : pk(SRC_SYN2, 1); // [R5]
        4'h4: r = pk(SRC_SYN1, 1); // [R5]
        4'h5: r = g6 ? pk(SRC_MAIN, 1) : pk(SRC_MAIN, 48); // [R6]
        4'h6: r = pk(SRC_MAIN, 16); // [R6]
        4'h7: r = pk(SRC_MAIN, 12); // [R6]
        4'h8: r = pk(SRC_MAIN, 8); // [R6]
        4'h9: r = g13 ? pk(SRC_MAIN, 8) : pk(SRC_MAIN, 6); // [R6] [R7]
        4'hA: r = pk(SRC_MAIN, 4); // [R6]
        4'hB: r = g45 ? pk(SRC_SEC, 2) : pk(SRC_SEC, 64); // [R8] [R9]
        4'hC: r = pk(SRC_SEC, 48); // [R8]
        4'hD: r = pk(SRC_SEC, 16); // [R8]
        4'hE: r = pk(SRC_SEC, 8); // [R8]
        4'hF: r = pk(SRC_SEC, 4); // [R8]
        default: r = pk(SRC_OFF, 1);
      endcase
    end else begin
      case (c)
        4'h1: r = g45 ? pk(SRC_MAIN, 2) : g6 ? pk(SRC_SEC, 5) : pk(SRC_MAIN, 64); // [R10] [R12]
        4'h2: r = g45 ? pk(SRC_MAIN, 1) : g6 ? pk(SRC_SEC, 2) : pk(SRC_SEC, 20); // [R10] [R12]
        4'h3: r = g45 ? pk(SRC_SEC, 10) : g6 ? pk(SRC_SEC, 1) : pk(SRC_SEC, 12); // [R10] [R12]
        4'h4: r = g45 ? pk(SRC_MAIN2, 2) : g6 ? pk(SRC_MAIN2, 5) : pk(SRC_SEC, 10); // [R10]
        4'h5: begin
          if (idx == 0) r = pk(SRC_MAIN2, 10); // [R11]
          else if (g45) r = pk(SRC_MAIN2, 2); // [R12]
          else if (g6) r = pk(SRC_MAIN2, 2);
          else r = pk(SRC_SEC, 5); // [R10]
        end
        4'h6: begin
          if (idx == 0) r = pk(SRC_MAIN2, 5); // [R11]
          else if (g45 || g6) r = pk(SRC_MAIN2, 1); // [R12]
          else r = pk(SRC_SEC, 2); // [R10]
        end
        4'h7: r = pk(SRC_SECREF, 1); // [R13]
        4'h8: r = pk(SRC_MAINREF, 1); // [R13]
        default: r = pk(SRC_OFF, 1); // [R14] undefined codes fail safe low
      endcase
    end
    return r;
  endfunction : decode

  // ==========================================================
  // register write path: address and data taken in either order
  always_comb begin
    next_aw_got = aw_got;
    next_aw_word = aw_word;
    next_w_got = w_got;
    next_wdata = wdata_q;
    next_wstrb = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp_q;
    next_sel = sel_reg;
    next_alt = alt_reg;
    wr_fire = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_word = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wdata = s_axi_wdata[7:0];
      next_wstrb = s_axi_wstrb[0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_got && w_got && !bvalid) begin
      wr_fire = 1'b1;
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      // only byte lane 0 carries register bits
      case (aw_word)
        IDX_SEL12: if (wstrb_q) next_sel[0] = wdata_q; // [R1]
        IDX_SEL34: if (wstrb_q) next_sel[1] = wdata_q; // [R1]
        IDX_SEL56: if (wstrb_q) next_sel[2] = wdata_q; // [R1]
        IDX_ALT: if (wstrb_q) next_alt = wdata_q[NUM_OUT-1:0]; // [R2]
        IDX_STAT: next_bresp = RESP_OKAY; // read-only, write dropped
        default: next_bresp = RESP_SLVERR;
      endcase
    end
  end

  // ==========================================================
  // register read path, answer one cycle after the address is taken
  always_comb begin
    ar_word = s_axi_araddr[ADDR_W-1:2];
    next_rvalid = rvalid;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0;
      case (ar_word)
        IDX_SEL12: next_rdata[7:0] = sel_reg[0];
        IDX_SEL34: next_rdata[7:0] = sel_reg[1];
        IDX_SEL56: next_rdata[7:0] = sel_reg[2];
        IDX_ALT: next_rdata[NUM_OUT-1:0] = alt_reg;
        IDX_STAT: begin
          next_rdata[STAT_OUT_LSB +: NUM_OUT] = clk_v;
          next_rdata[STAT_BUSY_LSB +: NUM_OUT] = busy_v;
        end
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got <= 1'b0;
      aw_word <= '0;
      w_got <= 1'b0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      bvalid <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
      sel_reg[0] <= RST_SEL12;
      sel_reg[1] <= RST_SEL34;
      sel_reg[2] <= RST_SEL56;
      alt_reg <= RST_ALT;
    end else begin
      aw_got <= next_aw_got;
      aw_word <= next_aw_word;
      w_got <= next_w_got;
      wdata_q <= next_wdata;
      wstrb_q <= next_wstrb;
      bvalid <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid <= next_rvalid;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
      sel_reg <= next_sel;
      alt_reg <= next_alt;
    end
  end

  assign s_axi_awready = !aw_got && !bvalid;
  assign s_axi_wready = !w_got && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // field split and per-output decode, registered to cut the table path
  always_comb begin
    dec = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      fld[i] = sel_reg[i / 2][((i % 2) != 0 ? HI_LSB : LO_LSB) +: FLD_W]; // [R1]
      dec = decode(i, alt_reg[i], fld[i]); // [R2] [R15]
      next_req_src[i] = ofs_src_t'(dec[DIV_W+3:DIV_W]);
      next_req_div[i] = dec[DIV_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_OUT; i++) begin
      if (rst) begin
        req_src[i] <= SRC_OFF;
        req_div[i] <= DIV_W'(1);
      end else begin
        req_src[i] <= next_req_src[i];
        req_div[i] <= next_req_div[i];
      end
    end
  end

  // ==========================================================
  // source vector indexed by source code; the off slot is tied low
  assign src_vec = {main_ref_div, secondary_ref_div, main_path_second_pll,
                    secondary_path_analog_pll, main_path_analog_pll, digital_synth_two,
                    digital_synth_one, frame_8k_clk, frame_2k_clk, 1'b0}; // [R3]

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    ofs_chan_if ch ();
    assign ch.req_src = req_src[g];
    assign ch.req_div = req_div[g];
    assign clk_v[g] = ch.clk_out;
    assign busy_v[g] = ch.busy;
    ofs_chan #(.HOLD(HOLD_CYC)) u_chan (
      .clk(clk),
      .rst(rst),
      .src_vec(src_vec),
      .port(ch.chan)
    );
  end

  assign clock_output_one = clk_v[0];
  assign clock_output_two = clk_v[1];
  assign clock_output_three = clk_v[2];
  assign clock_output_four = clk_v[3];
  assign clock_output_five = clk_v[4];
  assign clock_output_six = clk_v[5];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_field_write: assert property (wr_fire && aw_word == IDX_SEL34 && wstrb_q |=> // [R1]
      fld[2] == $past(wdata_q[3:0]) && fld[3] == $past(wdata_q[7:4]))
    else $error("select field not written");
  chk_zero_off: assert property (fld[1] == 4'h0 |=> req_src[1] == SRC_OFF) // [R3]
    else $error("code zero not disabled");
  chk_std_frame: assert property (!alt_reg[1] && fld[1] == 4'h1 |=> req_src[1] == SRC_2K) // [R4]
    else $error("2 kHz not selected");
  chk_std_synth: assert property (!alt_reg[2] && fld[2] == 4'h3 |=> req_src[2] == SRC_SYN2) // [R5]
    else $error("synth two not selected");
  chk_main_div48: assert property (!alt_reg[1] && fld[1] == 4'h5 |=> // [R6]
      req_src[1] == SRC_MAIN && req_div[1] == 7'd48)
    else $error("main divide by 48 wrong");
  chk_out1_div8: assert property (!alt_reg[0] && fld[0] == 4'h9 |=> req_div[0] == 7'd8) // [R7]
    else $error("output one code 9 not divide by 8");
  chk_sec_div64: assert property (!alt_reg[0] && fld[0] == 4'hB |=> // [R8]
      req_src[0] == SRC_SEC && req_div[0] == 7'd64)
    else $error("secondary divide by 64 wrong");
  chk_out4_div2: assert property (!alt_reg[3] && fld[3] == 4'hB |=> req_div[3] == 7'd2) // [R9]
    else $error("output four code B not divide by 2");
  chk_alt_main64: assert property (alt_reg[1] && fld[1] == 4'h1 |=> // [R10]
      req_src[1] == SRC_MAIN && req_div[1] == 7'd64)
    else $error("alternate main divide by 64 wrong");
  chk_alt_pll2: assert property (alt_reg[0] && fld[0] == 4'h6 |=> // [R11]
      req_src[0] == SRC_MAIN2 && req_div[0] == 7'd5)
    else $error("second main PLL divide by 5 wrong");
  chk_alt_out4: assert property (alt_reg[3] && fld[3] == 4'h2 |=> // [R12]
      req_src[3] == SRC_MAIN && req_div[3] == 7'd1)
    else $error("alternate output four code 2 wrong");
  chk_alt_ref: assert property (alt_reg[1] && fld[1] == 4'h7 |=> req_src[1] == SRC_SECREF) // [R13]
    else $error("secondary reference not selected");
  chk_out6_alt: assert property (alt_reg[5] && fld[5] == 4'h3 |=> // [R15]
      req_src[5] == SRC_SEC && req_div[5] == 7'd1)
    else $error("output six ignores its own alternate bit");
endmodule : ofs_top

// ### dv/ofs_meter.sv
`timescale 1ns/1ps
// ==========================================================
// downstream consumer: counts rising edges and the last period
module ofs_meter (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched output clock
  input wire logic sig,
  // measurements
  output logic [15:0] rises,
  output logic [15:0] period
);
  logic prev;
  logic [15:0] cnt;
  // period in clk cycles between two rising edges of the watched level
  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= 1'b0;
      cnt <= 16'h0000;
      rises <= 16'h0000;
      period <= 16'h0000;
    end else begin
      prev <= sig;
      cnt <= cnt + 16'h0001;
      if (sig && !prev) begin
        rises <= rises + 16'h0001;
        period <= cnt + 16'h0001;
        cnt <= 16'h0000;
      end
    end
  end
endmodule : ofs_meter

// ### dv/test_output_clock_freq_select.sv
`timescale 1ns/1ps
module test_output_clock_freq_select;
  import ofs_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [8:0] src = 9'h000;
  logic [5:0] outs;
  logic [2:0] sel_o = 3'h0;
  logic [15:0] rises, period;
  logic [31:0] rd;
  int half[9] = '{19, 23, 13, 17, 2, 3, 5, 7, 11};
  int cnt[9] = '{default: 0};
  int fail_count = 0, check_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  // ==========================================================
  // sources: 2k, 8k, synth1, synth2, main, sec, main2, secref, mainref
  always @(posedge clk) begin
    for (int i = 0; i < 9; i++) begin
      if (cnt[i] == half[i] - 1) begin
        cnt[i] <= 0;
        src[i] <= ~src[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
  ofs_top dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .frame_2k_clk(src[0]), .frame_8k_clk(src[1]), .digital_synth_one(src[2]),
    .digital_synth_two(src[3]), .main_path_analog_pll(src[4]),
    .secondary_path_analog_pll(src[5]), .main_path_second_pll(src[6]),
    .secondary_ref_div(src[7]), .main_ref_div(src[8]), .clock_output_one(outs[0]),
    .clock_output_two(outs[1]), .clock_output_three(outs[2]), .clock_output_four(outs[3]),
    .clock_output_five(outs[4]), .clock_output_six(outs[5]));
  // one meter behind a mux, so only the watched output needs settling time
  ofs_meter meter (.clk(clk), .rst(rst), .sig(outs[sel_o]), .rises(rises), .period(period));
  // ==========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      end_sim();
    end
  end
  // ==========================================================
  // axi4-lite master tasks
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    // no local limit: only the hang guard ends a wait for the answer
    while (!s_axi_bvalid) begin
      @(posedge clk);
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_arvalid && !s_axi_arready);
    while (!s_axi_rvalid) begin
      @(posedge clk);
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // ==========================================================
  // scenarios
  task automatic reg_check();
    axi_rd(12'h180);
    check(rd, 32'h85);
    axi_rd(12'h184);
    check(rd, 32'h86);
    axi_rd(12'h188);
    check(rd, 32'h84);
    axi_rd(12'h198);
    check(rd, 32'h0);
    axi_rd(12'h3FC);
    check(rd, 32'h0);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_wr(12'h188, 8'hC3);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    axi_rd(12'h188);
    check(rd, 32'hC3);
    // lane 0 strobe low: the write is answered but must not land
    s_axi_wstrb <= 4'hE;
    axi_wr(12'h188, 8'h00);
    s_axi_wstrb <= 4'hF;
    axi_rd(12'h188);
    check(rd, 32'hC3);
  endtask : reg_check
  // alt codes stay within 0..8, never the undefined ones
  task automatic run_case(input int o, input logic alt, input logic [3:0] code, input int per);
    int n;
    logic [15:0] r0;
    n = 0;
    sel_o <= 3'((o - 1));
    axi_wr(12'h180 + 12'(((o - 1) / 2) * 4), (o % 2) ? {4'h0, code} : {code, 4'h0});
    axi_wr(12'h198, alt ? 8'((1 << (o - 1))) : 8'h00);
    repeat (10) @(posedge clk);
    r0 = rises;
    if (per == 0) begin
      repeat (500) @(posedge clk);
      check(32'(rises - r0), 32'h0);
    end else begin
      while (rises < r0 + 16'h0003 && n < per * 8 + 400) begin
        @(posedge clk);
        n++;
      end
      // a stalled output would leave a stale period from the last case
      check(32'(rises - r0), 32'h3);
      check(32'(period), 32'(per));
    end
  endtask : run_case
  // ==========================================================
  // main sequence; expected period = divisor times source period
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reg_check();
    run_case(2, 1'b0, 4'h1, 38);
    run_case(1, 1'b0, 4'h2, 46);
    run_case(3, 1'b0, 4'h3, 34);
    run_case(4, 1'b0, 4'h4, 26);
    run_case(2, 1'b0, 4'h5, 192);
    run_case(4, 1'b0, 4'h9, 24);
    run_case(4, 1'b0, 4'hA, 16);
    run_case(1, 1'b0, 4'h9, 32);
    run_case(3, 1'b0, 4'h9, 32);
    run_case(1, 1'b0, 4'hB, 384);
    run_case(3, 1'b0, 4'hF, 24);
    run_case(4, 1'b0, 4'hB, 12);
    run_case(2, 1'b1, 4'h1, 256);
    run_case(3, 1'b1, 4'h2, 120);
    run_case(3, 1'b1, 4'h6, 12);
    run_case(1, 1'b1, 4'h5, 100);
    run_case(1, 1'b1, 4'h6, 50);
    run_case(4, 1'b1, 4'h2, 4);
    run_case(4, 1'b1, 4'h5, 20);
    run_case(2, 1'b1, 4'h7, 14);
    run_case(2, 1'b1, 4'h8, 22);
    run_case(5, 1'b0, 4'h2, 46);
    run_case(6, 1'b1, 4'h3, 6);
    run_case(6, 1'b0, 4'h5, 4);
    run_case(2, 1'b0, 4'h0, 0);
    run_case(6, 1'b1, 4'h0, 0);
    end_sim();
  end
endmodule : test_output_clock_freq_select
